// file: cus_regs.svh
// Register offsets, field positions, codes and timing counts of the status-reporting block.
`ifndef CUS_REGS_SVH
`define CUS_REGS_SVH
`define CUS_OFS_STATUS 4'h1
`define CUS_OFS_LOCATION 4'h2
`define CUS_UNIT_LO 0
`define CUS_UNIT_HI 7
`define CUS_RUN_LO 8
`define CUS_RUN_HI 11
`define CUS_ERR_LO 12
`define CUS_ERR_HI 15
`define CUS_DIGIT_RUN 4'h1
`define CUS_DIGIT_STOP 4'h0
`define CUS_DIGIT_FATAL 4'h8
`define CUS_DIGIT_OK 4'h0
`define CUS_CODE_NONE 8'h00
`define CUS_CODE_SYNTAX 8'h02
`define CUS_CODE_WDT 8'h01
`define CUS_CODE_ALLOC 8'h15
`define CUS_WORD_ZERO 16'h0000
`define CUS_FLASH_MS 250
`define CUS_CLK_HZ 25000000
`define CUS_FLASH_CYC ((`CUS_CLK_HZ / 1000) * `CUS_FLASH_MS)
`endif

// file: cus_pkg.sv
// Types shared by the status-reporting block.
package cus_pkg;
   typedef logic [15:0] cus_word_t;
   typedef logic [7:0] cus_bcd2_t;
   typedef enum logic [1:0] {
      CUS_IDLE,
      CUS_RUN,
      CUS_SYNTAX_HALT,
      CUS_FATAL_HALT
   } cus_state_t;
endpackage

// file: cus_wr_if.sv
// Word write path from the status logic to the shared word memory writer.
`timescale 1ns/1ps
interface cus_wr_if;
   import cus_pkg::*;
   logic valid;
   logic [3:0] offset;
   cus_word_t data;
   modport src (output valid, output offset, output data);
   modport dst (input valid, input offset, input data);
endinterface

// file: cus_word_store.sv
// Holds the two status words and returns read data from a register.
`timescale 1ns/1ps
`include "cus_regs.svh"
module cus_word_store (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Write side
   cus_wr_if.dst wr,
   // Read side
   input wire logic [3:0] rd_offset,
   output cus_pkg::cus_word_t rd_data
);
   import cus_pkg::*;
   cus_word_t status_q, status_d;
   cus_word_t loc_q, loc_d;
   cus_word_t rd_q, rd_d;

   always_comb begin
      status_d = status_q;
      loc_d = loc_q;
      // The whole word lands in one write, never field by field.
      if (wr.valid && wr.offset == `CUS_OFS_STATUS) begin
         status_d = wr.data;
      end
      if (wr.valid && wr.offset == `CUS_OFS_LOCATION) begin
         loc_d = wr.data;
      end
      case (rd_offset)
         `CUS_OFS_STATUS: rd_d = status_q;
         `CUS_OFS_LOCATION: rd_d = loc_q;
         default: rd_d = `CUS_WORD_ZERO;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= `CUS_WORD_ZERO;
         loc_q <= `CUS_WORD_ZERO;
         rd_q <= `CUS_WORD_ZERO;
      end else begin
         status_q <= status_d;
         loc_q <= loc_d;
         rd_q <= rd_d;
      end
   end

   assign rd_data = rd_q;
endmodule

// file: cus_status.sv
// Status word and syntax-error location reporting of the polling unit.
//
// How it works
// - Without fatal error, low byte holds BCD number of last completed component.
// - After reset, before any completion, the component number reads zero.
// - Component number is zero when count zero, stopped, or no unit connected.
// - Bits 8 to 11 read 1 while running, 0 while stopped.
// - Top digit is 0, bit 15 clear, while no fatal error exists.
// - Unwritable memory, lost CPU link, write-protect count as unreportable fatal errors.
// - Unreportable fatal error halts all communication and lights the indicator steadily.
// - Syntax error writes the faulty address as four BCD digits at offset 2.
// - Only the first syntax error address is kept; later ones are ignored.
// - Reportable fatal error (watchdog, allocation) while idle or running sets top digit 8 and an error code in the low byte.
// - Syntax error stops communication, stores location, then flashes the indicator.
`timescale 1ns/1ps
`include "cus_regs.svh"
module cus_status (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Settings from the control word
   input wire logic run_setting,
   input wire logic [7:0] component_count,
   // Polling engine events
   input wire logic read_done,
   input wire logic [4:0] read_unit,
   input wire logic read_unit_none,
   input wire logic syntax_err,
   input wire logic [15:0] syntax_addr,
   input wire logic wdt_err,
   input wire logic alloc_err,
   // Unreportable fatal conditions
   input wire logic mem_unwritable,
   input wire logic cpu_link_fail,
   input wire logic prog_protect,
   // Host read port of the shared word memory
   input wire logic [3:0] rd_offset,
   output cus_pkg::cus_word_t rd_data,
   // Unit control and indicator
   output logic comms_enable,
   output logic err_led
);
   import cus_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic cus_bcd2_t to_bcd2(input logic [4:0] bin);
      logic [3:0] tens;
      logic [3:0] ones;
      tens = 4'(bin / 5'd10);
      ones = 4'(bin % 5'd10);
      return {tens, ones};
   endfunction

   function automatic logic [3:0] bcd_digit(input logic [15:0] bin, input logic [13:0] div);
      logic [15:0] q;
      q = bin / {2'b00, div};
      return 4'(q % 16'd10);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   localparam int unsigned FLASH_CYC = `CUS_FLASH_CYC;

   cus_state_t state_q, state_d;
   cus_bcd2_t unit_q, unit_d;
   logic [7:0] code_q, code_d;
   logic loc_set_q, loc_set_d;
   logic led_q, led_d;
   logic [22:0] flash_q, flash_d;
   cus_word_t word_q, word_d;

   cus_wr_if wr_bus ();

   logic stopped;
   logic unreportable;
   logic reportable_fatal;

   always_comb begin
      unreportable = mem_unwritable || cpu_link_fail || prog_protect;
      reportable_fatal = wdt_err || alloc_err;
      stopped = !run_setting || component_count == 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and reporting

   always_comb begin
      state_d = state_q;
      unit_d = unit_q;
      code_d = code_q;
      loc_set_d = loc_set_q;
      led_d = led_q;
      flash_d = flash_q;
      word_d = word_q;
      wr_bus.valid = 1'b0;
      wr_bus.offset = `CUS_OFS_STATUS;
      wr_bus.data = word_q;

      case (state_q)
         CUS_IDLE, CUS_RUN: begin
            if (unreportable) begin
               // Nothing can reach the host, so only the indicator tells.
               state_d = CUS_FATAL_HALT;
               led_d = 1'b1;
            end else if (reportable_fatal) begin
               code_d = wdt_err ? `CUS_CODE_WDT : `CUS_CODE_ALLOC;
               state_d = CUS_FATAL_HALT;
               led_d = 1'b1;
            end else if (syntax_err) begin
               state_d = CUS_SYNTAX_HALT;
               code_d = `CUS_CODE_SYNTAX;
               if (!loc_set_q) begin
                  loc_set_d = 1'b1;
                  wr_bus.valid = 1'b1;
                  wr_bus.offset = `CUS_OFS_LOCATION;
                  wr_bus.data = {bcd_digit(syntax_addr, 14'd1000),
                                 bcd_digit(syntax_addr, 14'd100),
                                 bcd_digit(syntax_addr, 14'd10),
                                 bcd_digit(syntax_addr, 14'd1)};
               end
            end else begin
               state_d = stopped ? CUS_IDLE : CUS_RUN;
               if (stopped) begin
                  unit_d = `CUS_CODE_NONE;
               end else if (read_done) begin
                  unit_d = read_unit_none ? `CUS_CODE_NONE : to_bcd2(read_unit);
               end
            end
         end
         CUS_SYNTAX_HALT: begin
            // Flash only after the location word has been written.
            if (flash_q == 23'(FLASH_CYC - 1)) begin
               flash_d = '0;
               led_d = !led_q;
            end else begin
               flash_d = flash_q + 23'd1;
            end
            if (unreportable) begin
               state_d = CUS_FATAL_HALT;
               led_d = 1'b1;
            end
         end
         CUS_FATAL_HALT: begin
            led_d = 1'b1;
         end
         default: state_d = CUS_IDLE;
      endcase

      // Status word assembled in full, then written as one word.
      if (state_d == CUS_FATAL_HALT && code_d != `CUS_CODE_NONE
          && code_d != `CUS_CODE_SYNTAX) begin
         word_d = {`CUS_DIGIT_FATAL, `CUS_DIGIT_STOP, code_d};
      end else begin
         word_d = {`CUS_DIGIT_OK,
                   (state_d == CUS_RUN) ? `CUS_DIGIT_RUN : `CUS_DIGIT_STOP,
                   unit_d};
      end
      if (!wr_bus.valid && word_d != word_q && !(state_q == CUS_FATAL_HALT)) begin
         wr_bus.valid = 1'b1;
         wr_bus.offset = `CUS_OFS_STATUS;
         wr_bus.data = word_d;
      end else if (wr_bus.valid) begin
         word_d = word_q; // Retried next cycle; the location write took the port.
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= CUS_IDLE;
         unit_q <= `CUS_CODE_NONE;
         code_q <= `CUS_CODE_NONE;
         loc_set_q <= 1'b0;
         led_q <= 1'b0;
         flash_q <= '0;
         word_q <= `CUS_WORD_ZERO;
      end else begin
         state_q <= state_d;
         unit_q <= unit_d;
         code_q <= code_d;
         loc_set_q <= loc_set_d;
         led_q <= led_d;
         flash_q <= flash_d;
         word_q <= word_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Storage and outputs

   cus_word_store u_store (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr(wr_bus),
      .rd_offset(rd_offset),
      .rd_data(rd_data)
   );

   assign comms_enable = (state_q == CUS_RUN);
   assign err_led = led_q;
endmodule

// file: cus_cpu_model.sv
// Host processor model that selects a word and reads it back whole.
`timescale 1ns/1ps
module cus_cpu_model (
   // Clock and selection
   input wire logic ref_clk,
   input wire logic [3:0] sel,
   // Read port
   output logic [3:0] rd_offset,
   input wire cus_pkg::cus_word_t rd_data,
   output cus_pkg::cus_word_t word
);
   import cus_pkg::*;
   initial rd_offset = 4'h0;
   always @(negedge ref_clk) rd_offset <= sel;
   assign word = rd_data;
endmodule

// file: cus_status_checker.sv
// Concurrent checks on the ports of the status block.
`timescale 1ns/1ps
module cus_status_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Inputs
   input wire logic run_setting,
   input wire logic [7:0] component_count,
   input wire logic read_done,
   input wire logic [4:0] read_unit,
   input wire logic read_unit_none,
   input wire logic syntax_err,
   input wire logic [15:0] syntax_addr,
   input wire logic wdt_err,
   input wire logic alloc_err,
   input wire logic mem_unwritable,
   input wire logic cpu_link_fail,
   input wire logic prog_protect,
   input wire logic [3:0] rd_offset,
   // Outputs
   input wire cus_pkg::cus_word_t rd_data,
   input wire logic comms_enable,
   input wire logic err_led
);
   import cus_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic got_q;
   logic [15:0] loc_q;
   wire unrep = mem_unwritable | cpu_link_fail | prog_protect;
   wire quiet = !(read_done | syntax_err | wdt_err | alloc_err);
   function automatic logic [15:0] bcd(int v);
      return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction
   // The first address is latched here so the check sees the later ones ignored.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         got_q <= 1'b0;
         loc_q <= 16'h0000;
      end else if (syntax_err && !got_q) begin
         got_q <= 1'b1;
         loc_q <= bcd(int'(syntax_addr));
      end
   end
   sequence s_done;
      read_done && comms_enable && component_count != 8'h00 && !unrep;
   endsequence
   sequence s_wdt;
      wdt_err && !alloc_err && comms_enable && !unrep;
   endsequence
   a_unrep_halt: assert property (unrep |=> !comms_enable && err_led)
      else $error("unreportable fault did not halt");
   a_fatal_code: assert property ($past(rd_offset) == 4'h1 && rd_data[15] |-> rd_data[15:8] == 8'h80
      && (rd_data[7:0] == 8'h01 || rd_data[7:0] == 8'h15))
      else $error("bad fatal status");
   a_wdt_report: assert property (s_wdt ##1 rd_offset == 4'h1 |=> rd_data == 16'h8001)
      else $error("watchdog not reported");
   a_run_digit: assert property ((comms_enable && rd_offset == 4'h1 && quiet) [*3]
      |=> rd_data[15:8] == 8'h01)
      else $error("running status digits wrong");
   a_stop_zero: assert property ((!run_setting && !unrep && rd_offset == 4'h1 && quiet) [*4]
      |=> rd_data == 16'h0000 || rd_data[15])
      else $error("stopped status not zero");
   a_unit_bcd: assert property (s_done ##1 (rd_offset == 4'h1 && quiet && comms_enable)
      |=> rd_data[7:0] == ($past(read_unit_none, 2) ? 8'h00 : bcd($past(read_unit, 2))))
      else $error("unit number wrong");
   a_syn_halt: assert property (syntax_err && !unrep |-> ##[1:2] !comms_enable)
      else $error("syntax error did not stop polling");
   a_loc_first: assert property ($past(rd_offset) == 4'h2 && $past(got_q, 2) |-> rd_data == loc_q)
      else $error("location word wrong");
endmodule
bind cus_status cus_status_checker cus_status_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
   .run_setting(run_setting), .component_count(component_count), .read_done(read_done),
   .read_unit(read_unit), .read_unit_none(read_unit_none), .syntax_err(syntax_err),
   .syntax_addr(syntax_addr), .wdt_err(wdt_err), .alloc_err(alloc_err),
   .mem_unwritable(mem_unwritable), .cpu_link_fail(cpu_link_fail), .prog_protect(prog_protect),
   .rd_offset(rd_offset), .rd_data(rd_data), .comms_enable(comms_enable), .err_led(err_led));

// file: comm_unit_status_reporting_tb_top.sv
// Self-checking bench of the status block.
`timescale 1ns/1ps
module comm_unit_status_reporting_tb_top;
   import cus_pkg::*;
   logic ref_clk = 0, rst_n = 0, run = 0, done = 0, none = 0, syn = 0, wdt = 0, alc = 0;
   logic [2:0] unrep = 3'b000;
   logic [7:0] cnt = 8'h00;
   logic [4:0] unit = 5'h00;
   logic [15:0] addr = 16'h0000, a0;
   logic [3:0] sel = 4'h0, rd_offset;
   cus_word_t rd_data, word;
   logic comms_enable, err_led;
   int mismatches = 0, cmp_count = 0;
   cus_status cus_status_i (.ref_clk(ref_clk), .rst_n(rst_n), .run_setting(run),
      .component_count(cnt), .read_done(done), .read_unit(unit), .read_unit_none(none),
      .syntax_err(syn), .syntax_addr(addr), .wdt_err(wdt), .alloc_err(alc),
      .mem_unwritable(unrep[0]), .cpu_link_fail(unrep[1]), .prog_protect(unrep[2]),
      .rd_offset(rd_offset), .rd_data(rd_data), .comms_enable(comms_enable), .err_led(err_led));
   cus_cpu_model cus_cpu_model_i (.ref_clk(ref_clk), .sel(sel), .rd_offset(rd_offset),
      .rd_data(rd_data), .word(word));
   initial forever #20 ref_clk = ~ref_clk;
   function automatic logic [15:0] bcd(int v);
      return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd(logic [3:0] o, logic [15:0] exp);
      sel = o;
      repeat (3) @(negedge ref_clk);
      chk(word, exp);
   endtask
   // Every test starts from reset, since errors are only cleared that way.
   task automatic restart();
      rst_n = 0;
      {run, done, syn, wdt, alc, unrep} = '0;
      repeat (20) @(negedge ref_clk);
      rst_n = 1;
      @(negedge ref_clk);
      {run, cnt} = {1'b1, 8'h01};
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #(40 * 8000);
      mismatches++;
      complete_run();
   end
   initial begin
      void'($urandom(32'h9e7033c8));
      repeat (20) @(negedge ref_clk);
      rst_n = 1;
      rd(4'h1, 16'h0000);
      rd(4'h2, 16'h0000);
      restart();
      rd(4'h1, 16'h0100);
      for (int i = 0; i < 12; i++) begin
         {unit, none} = {5'($urandom_range(31)), 1'(i % 4 == 3)};
         if (i == 0) unit = 5'd31;
         done = 1;
         @(negedge ref_clk);
         done = 0;
         rd(4'h1, {8'h01, none ? 8'h00 : 8'(bcd(int'(unit)))});
      end
      run = 0;
      rd(4'h1, 16'h0000);
      $display("test polling done");
      restart();
      a0 = 16'($urandom_range(9999));
      for (int i = 0; i < 2; i++) begin
         {syn, addr} = {1'b1, i == 0 ? a0 : 16'd9999 - a0};
         @(negedge ref_clk);
         syn = 0;
      end
      rd(4'h2, bcd(int'(a0)));
      chk({15'h0000, comms_enable}, 16'h0000);
      $display("test syntax done");
      for (int k = 0; k < 5; k++) begin
         restart();
         if (k < 2) {wdt, alc} = k == 0 ? 2'b10 : 2'b01;
         else unrep[k - 2] = 1'b1;
         @(negedge ref_clk);
         {wdt, alc} = 2'b00;
         if (k < 2) rd(4'h1, k == 0 ? 16'h8001 : 16'h8015);
         chk({14'h0000, comms_enable, err_led}, 16'h0001);
      end
      $display("test fatal done");
      complete_run();
   end
endmodule
